// ---- hazard_seq_if.sv ----
// Sequence signals between checker core and history tracker
`timescale 1ns/1ns
`default_nettype none

interface hazard_seq_if;
  logic valid;
  logic ret;
  logic call;
  logic halt;
  logic pm_field;
  logic brk;
  logic bus_branch;
  logic set_flag;
  logic flag_branch;
  logic load_status;
  logic status_branch;
  logic ret_pair;
  logic pm_call;
  logic halt_call;
  logic brk_call;
  logic bus_zeroed;
  logic flag_stale;
  logic status_stale;
  modport core (
    output valid, ret, call, halt, pm_field, brk, bus_branch,
    output set_flag, flag_branch, load_status, status_branch,
    input  ret_pair, pm_call, halt_call, brk_call, bus_zeroed,
    input  flag_stale, status_stale
  );
  modport tracker (
    input  valid, ret, call, halt, pm_field, brk, bus_branch,
    input  set_flag, flag_branch, load_status, status_branch,
    output ret_pair, pm_call, halt_call, brk_call, bus_zeroed,
    output flag_stale, status_stale
  );
endinterface

`default_nettype wire

// ---- microword_hazard_pkg.sv ----
// Types shared by the microword hazard checker
`include "microword_hazard_regs.svh"

package microword_hazard_pkg;
  typedef logic signed [2:0] pad_offset_t;
  typedef logic [`ERR_WIDTH-1:0] err_vec_t;
  typedef logic [`STATUS_WIDTH-1:0] status_t;
endpackage

// ---- microword_hazard_regs.svh ----
// Constants for the microword hazard checker
`ifndef MICROWORD_HAZARD_REGS_SVH
`define MICROWORD_HAZARD_REGS_SVH

`define PAD_DEPTH         32
`define STACK_DEPTH       16
`define DATA_WIDTH        32
`define STATUS_WIDTH      4

`define BUS_SRC_MEMORY    0
`define BUS_SRC_PAD_X     1
`define BUS_SRC_PAD_Y     2
`define BUS_SRC_VALUE     3

`define PAD_SRC_BUS       0
`define PAD_SRC_ADDER     1
`define PAD_SRC_MULT      2

`define ERR_RET_PAIR      0
`define ERR_PM_CALL       1
`define ERR_BRK_CALL      2
`define ERR_PM_BUS_BRANCH 3
`define ERR_HALT_CALL     4
`define ERR_FLAG_STALE    5
`define ERR_STATUS_STALE  6
`define ERR_BUS_MULTI     7
`define ERR_X_WRITES      8
`define ERR_Y_WRITES      9
`define ERR_X_READS       10
`define ERR_Y_READS       11
`define ERR_NOLOAD_BRANCH 12
`define ERR_STACK_OVF     13
`define ERR_WIDTH         14

`define SOFT_FLAG_RESET   1'h0
`define STATUS_RESET      4'h0
`define BRANCH_SEE_DELAY  1

`endif

// ---- microword_hazard_rules.sv ----
// Microword datapath hazard checker with data pad and stack pointer
`timescale 1ns/1ns
`default_nettype none

`include "microword_hazard_regs.svh"

// Behaviour
// - Return pairs, field op then call, or break then call slip the stack pointer.
// - Halt then call slips the stack pointer; repeating it overflows the stack.
// - Bus negative or zero branch right after a field op sees a zero bus.
// - Flag and status branches see new values only two cycles later.
// - One pad bus source per cycle; one value may reach many destinations.
// - Adder and multiplier results write the pad without using the bus.
// - At most one write into each pad half per cycle.
// - Several reads of one half are legal only at one shared index.
// - A pad read in the write cycle returns the old stored value.
// - Pointer and scratch load take the bus; pad access uses the old pointer.
// - The scratch no-load modifier cannot be combined with a conditional branch.
// - Pad offsets are signed, four below to three above the pointer.
module microword_hazard_rules #(
  parameter int W           = `DATA_WIDTH,
  parameter int PAD_DEPTH   = `PAD_DEPTH,
  parameter int STACK_DEPTH = `STACK_DEPTH
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 srst,
  input  wire logic                                 instr_valid,
  input  wire logic                                 ret_op,
  input  wire logic                                 call_op,
  input  wire logic                                 halt_op,
  input  wire logic                                 pm_field_op,
  input  wire logic                                 panel_break,
  input  wire logic                                 set_soft_flag,
  input  wire logic                                 soft_flag_value,
  input  wire logic                                 branch_on_soft_flag,
  input  wire logic                                 load_processor_status,
  input  wire microword_hazard_pkg::status_t        status_value,
  input  wire logic                                 branch_on_status,
  input  wire microword_hazard_pkg::status_t        status_mask,
  input  wire logic                                 branch_bus_negative,
  input  wire logic                                 branch_bus_zero,
  input  wire logic                                 cond_branch,
  input  wire logic                                 scratch_no_load,
  input  wire logic [3:0]                           bus_req,
  input  wire logic [W-1:0]                         value_word,
  input  wire logic [W-1:0]                         memory_read_value,
  input  wire logic [W-1:0]                         adder_result,
  input  wire logic [W-1:0]                         multiplier_result,
  input  wire logic [1:0][2:0]                      wr_req,
  input  wire microword_hazard_pkg::pad_offset_t [1:0][2:0] wr_off,
  input  wire logic [1:0][2:0]                      rd_req,
  input  wire microword_hazard_pkg::pad_offset_t [1:0][2:0] rd_off,
  input  wire logic                                 load_pad_pointer,
  input  wire logic                                 load_scratch_indirect,
  output logic [W-1:0]                              pad_bus_out,
  output logic [W-1:0]                              operand_x,
  output logic [W-1:0]                              operand_y,
  output logic [W-1:0]                              scratch_data,
  output logic                                      scratch_load,
  output logic [$clog2(PAD_DEPTH)-1:0]              pad_index_pointer,
  output logic                                      branch_taken,
  output logic [$clog2(STACK_DEPTH)-1:0]            stack_pointer,
  output logic                                      stack_overflow,
  output microword_hazard_pkg::err_vec_t            hazard_err
);
  localparam int PA_W = $clog2(PAD_DEPTH);
  localparam int SP_W = $clog2(STACK_DEPTH);

  hazard_seq_if seq ();

  microword_seq_tracker u_tracker (
    .clk_sys (clk_sys),
    .srst    (srst),
    .seq     (seq)
  );

  logic                             brk_meta_reg;
  logic                             brk_sync_reg;
  logic [W-1:0]                     bus_val;
  logic [W-1:0]                     eff_bus;
  logic [1:0]                       wr_multi;
  logic [1:0]                       rd_clash;
  logic [W-1:0]                     rd_val [2];
  logic [W-1:0]                     operand_reg [2];
  logic [PA_W-1:0]                  ptr_reg;
  logic [PA_W-1:0]                  ptr_next;
  logic [W-1:0]                     bus_out_reg;
  logic [W-1:0]                     scratch_reg;
  logic [W-1:0]                     scratch_next;
  logic                             scratch_load_reg;
  logic                             flag_reg;
  logic                             flag_next;
  logic                             flag_seen_reg;
  microword_hazard_pkg::status_t    status_reg;
  microword_hazard_pkg::status_t    status_next;
  microword_hazard_pkg::status_t    status_seen_reg;
  logic                             taken_reg;
  logic                             taken_next;
  logic [SP_W-1:0]                  sp_reg;
  logic [SP_W-1:0]                  sp_next;
  logic [SP_W:0]                    sp_sum;
  logic [1:0]                       sp_inc;
  logic                             ovf_reg;
  logic                             ovf_next;
  microword_hazard_pkg::err_vec_t   err_reg;
  microword_hazard_pkg::err_vec_t   err_next;
  logic                             any_branch;

  assign seq.valid         = instr_valid;
  assign seq.ret           = ret_op;
  assign seq.call          = call_op;
  assign seq.halt          = halt_op;
  assign seq.pm_field      = pm_field_op;
  assign seq.brk           = brk_sync_reg;
  assign seq.bus_branch    = branch_bus_negative | branch_bus_zero;
  assign seq.set_flag      = set_soft_flag;
  assign seq.flag_branch   = branch_on_soft_flag;
  assign seq.load_status   = load_processor_status;
  assign seq.status_branch = branch_on_status;

  // Single bus driver, lowest source number wins on a clash
  always_comb begin
    bus_val = '0;
    if (bus_req[`BUS_SRC_VALUE])  bus_val = value_word;
    if (bus_req[`BUS_SRC_PAD_Y])  bus_val = rd_val[1];
    if (bus_req[`BUS_SRC_PAD_X])  bus_val = rd_val[0];
    if (bus_req[`BUS_SRC_MEMORY]) bus_val = memory_read_value;
    eff_bus = seq.bus_zeroed ? '0 : bus_val;
  end

  // One data pad half per loop pass: X then Y
  for (genvar h = 0; h < 2; h++) begin : g_half
    logic [W-1:0]    mem [PAD_DEPTH];
    logic [PA_W-1:0] waddr;
    logic [PA_W-1:0] raddr;
    logic [W-1:0]    wdata;
    logic            wen;

    always_comb begin
      // More than one writer in a half is a conflict
      wr_multi[h] = |(wr_req[h] & (wr_req[h] - 3'h1));
      rd_clash[h] = 1'h0;
      for (int j = 0; j < 3; j++) begin
        for (int k = j + 1; k < 3; k++) begin
          if (rd_req[h][j] && rd_req[h][k] && rd_off[h][j] != rd_off[h][k]) begin
            rd_clash[h] = 1'h1;
          end
        end
      end
      // Offsets are signed steps from the pointer held before this cycle
      raddr = PA_W'(ptr_reg + PA_W'(rd_off[h][`PAD_SRC_BUS]));
      if (!rd_req[h][`PAD_SRC_BUS]) begin
        raddr = rd_req[h][`PAD_SRC_ADDER] ? PA_W'(ptr_reg + PA_W'(rd_off[h][`PAD_SRC_ADDER]))
                                          : PA_W'(ptr_reg + PA_W'(rd_off[h][`PAD_SRC_MULT]));
      end
      wen   = instr_valid & (|wr_req[h]);
      waddr = PA_W'(ptr_reg + PA_W'(wr_off[h][`PAD_SRC_MULT]));
      wdata = multiplier_result;
      if (wr_req[h][`PAD_SRC_ADDER]) begin
        waddr = PA_W'(ptr_reg + PA_W'(wr_off[h][`PAD_SRC_ADDER]));
        wdata = adder_result;
      end
      if (wr_req[h][`PAD_SRC_BUS]) begin
        waddr = PA_W'(ptr_reg + PA_W'(wr_off[h][`PAD_SRC_BUS]));
        wdata = bus_val;
      end
    end

    // Stored value is read before the write lands at the edge
    assign rd_val[h] = mem[raddr];

    always_ff @(posedge clk_sys) begin
      if (wen) begin
        mem[waddr] <= wdata;
      end
      if (srst) begin
        operand_reg[h] <= '0;
      end else begin
        operand_reg[h] <= rd_val[h];
      end
    end

    a_half_writes: assert property (@(posedge clk_sys) disable iff (srst)
      instr_valid && !$onehot0(wr_req[h]) |=> hazard_err[`ERR_X_WRITES + h])
      else $error("double pad write not flagged");
    a_half_reads: assert property (@(posedge clk_sys) disable iff (srst)
      instr_valid && rd_clash[h] |=> hazard_err[`ERR_X_READS + h])
      else $error("pad read clash not flagged");
  end

  assign any_branch = cond_branch | branch_bus_negative | branch_bus_zero |
                      branch_on_soft_flag | branch_on_status;

  // Next state for pointer, flags, branch, stack and errors
  always_comb begin
    ptr_next     = ptr_reg;
    scratch_next = scratch_reg;
    flag_next    = flag_reg;
    status_next  = status_reg;
    sp_inc       = 2'h0;
    sp_next      = sp_reg;
    ovf_next     = ovf_reg;
    taken_next   = 1'h0;
    err_next     = '0;
    if (instr_valid && load_pad_pointer) begin
      ptr_next = bus_val[PA_W-1:0];
    end
    if (instr_valid && load_scratch_indirect) begin
      scratch_next = bus_val;
    end
    if (instr_valid && set_soft_flag) begin
      flag_next = soft_flag_value;
    end
    if (instr_valid && load_processor_status) begin
      status_next = status_value;
    end
    if (instr_valid) begin
      // Flag and status branches read the copies that lag one cycle
      taken_next = (branch_bus_negative & eff_bus[W-1]) |
                   (branch_bus_zero & (eff_bus == '0)) |
                   (branch_on_soft_flag & flag_seen_reg) |
                   (branch_on_status & (|(status_seen_reg & status_mask)));
    end
    // A slipped call pushes twice; a second return in a row does not pop
    if (instr_valid && call_op) begin
      sp_inc = (seq.pm_call | seq.halt_call | seq.brk_call) ? 2'h2 : 2'h1;
    end
    sp_sum = {1'h0, sp_reg} + (SP_W + 1)'(sp_inc);
    if (sp_sum > (SP_W + 1)'(STACK_DEPTH - 1)) begin
      sp_next  = SP_W'(STACK_DEPTH - 1);
      ovf_next = 1'h1;
    end else begin
      sp_next = sp_sum[SP_W-1:0];
    end
    if (instr_valid && ret_op && !call_op && !seq.ret_pair && sp_reg != '0) begin
      sp_next = sp_reg - SP_W'(1);
    end
    err_next[`ERR_RET_PAIR]      = seq.ret_pair;
    err_next[`ERR_PM_CALL]       = seq.pm_call;
    err_next[`ERR_BRK_CALL]      = seq.brk_call;
    err_next[`ERR_PM_BUS_BRANCH] = seq.bus_zeroed;
    err_next[`ERR_HALT_CALL]     = seq.halt_call;
    err_next[`ERR_FLAG_STALE]    = seq.flag_stale;
    err_next[`ERR_STATUS_STALE]  = seq.status_stale;
    err_next[`ERR_BUS_MULTI]     = instr_valid & !$onehot0(bus_req);
    err_next[`ERR_X_WRITES]      = instr_valid & wr_multi[0];
    err_next[`ERR_Y_WRITES]      = instr_valid & wr_multi[1];
    err_next[`ERR_X_READS]       = instr_valid & rd_clash[0];
    err_next[`ERR_Y_READS]       = instr_valid & rd_clash[1];
    err_next[`ERR_NOLOAD_BRANCH] = instr_valid & scratch_no_load & any_branch;
    err_next[`ERR_STACK_OVF]     = instr_valid & call_op & ovf_next & !ovf_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      brk_meta_reg     <= 1'h0;
      brk_sync_reg     <= 1'h0;
      ptr_reg          <= '0;
      scratch_reg      <= '0;
      scratch_load_reg <= 1'h0;
      bus_out_reg      <= '0;
      flag_reg         <= `SOFT_FLAG_RESET;
      flag_seen_reg    <= `SOFT_FLAG_RESET;
      status_reg       <= `STATUS_RESET;
      status_seen_reg  <= `STATUS_RESET;
      taken_reg        <= 1'h0;
      sp_reg           <= '0;
      ovf_reg          <= 1'h0;
      err_reg          <= '0;
    end else begin
      brk_meta_reg     <= panel_break;
      brk_sync_reg     <= brk_meta_reg;
      ptr_reg          <= ptr_next;
      scratch_reg      <= scratch_next;
      scratch_load_reg <= instr_valid & load_scratch_indirect;
      bus_out_reg      <= bus_val;
      flag_reg         <= flag_next;
      flag_seen_reg    <= flag_reg;
      status_reg       <= status_next;
      status_seen_reg  <= status_reg;
      taken_reg        <= taken_next;
      sp_reg           <= sp_next;
      ovf_reg          <= ovf_next;
      err_reg          <= err_next;
    end
  end

  assign pad_bus_out       = bus_out_reg;
  assign operand_x         = operand_reg[0];
  assign operand_y         = operand_reg[1];
  assign scratch_data      = scratch_reg;
  assign scratch_load      = scratch_load_reg;
  assign pad_index_pointer = ptr_reg;
  assign branch_taken      = taken_reg;
  assign stack_pointer     = sp_reg;
  assign stack_overflow    = ovf_reg;
  assign hazard_err        = err_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_set_quiet;
    instr_valid && set_soft_flag ##1 !(instr_valid && set_soft_flag);
  endsequence

  a_bus_single: assert property (instr_valid && !$onehot0(bus_req) |=> hazard_err[`ERR_BUS_MULTI])
    else $error("bus double drive not flagged");
  a_bus_two_dest: assert property (instr_valid && bus_req == 4'h1 && wr_req[0] == 3'h1 && wr_req[1] == 3'h1
    |=> !hazard_err[`ERR_BUS_MULTI] && !hazard_err[`ERR_X_WRITES] && !hazard_err[`ERR_Y_WRITES]
    && pad_bus_out == $past(memory_read_value))
    else $error("bus value not shared");
  a_pointer_load: assert property (instr_valid && load_pad_pointer |=> pad_index_pointer == $past(bus_val[PA_W-1:0]))
    else $error("pointer not loaded from bus");
  a_scratch_load: assert property (instr_valid && load_scratch_indirect |=> scratch_load && scratch_data == $past(bus_val))
    else $error("scratch not loaded from bus");
  a_noload_branch: assert property (instr_valid && scratch_no_load && cond_branch |=> hazard_err[`ERR_NOLOAD_BRANCH])
    else $error("no-load with branch not flagged");
  a_flag_lag: assert property (s_set_quiet |=> flag_seen_reg == $past(soft_flag_value, 2))
    else $error("flag not visible two cycles on");
  a_zero_bus_branch: assert property (seq.bus_zeroed && branch_bus_zero |=> branch_taken)
    else $error("zeroed bus branch not taken");
  a_stack_double: assert property (instr_valid && call_op && seq.halt_call && int'(stack_pointer) < STACK_DEPTH - 2
    |=> int'(stack_pointer) == int'($past(stack_pointer)) + 2)
    else $error("halt then call did not slip");
  a_ret_hold: assert property (seq.ret_pair && !call_op |=> $stable(stack_pointer))
    else $error("second return popped");
  a_ovf_sticky: assert property (stack_overflow |=> stack_overflow)
    else $error("overflow flag dropped");
endmodule

`default_nettype wire

// ---- microword_hazard_rules_bench.sv ----
// Self-checking bench for the microword hazard checker
`timescale 1ns/1ns
`default_nettype none
module microword_hazard_rules_bench;
  localparam int RET = 1, CALL = 2, HALT = 4, PM = 8, SETF = 16, BFL = 32, LDST = 64, BST = 128;
  localparam int BBN = 256, BBZ = 512, CBR = 1024, NOLD = 2048, NOP = 4096, BRK = 8192;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic instr_valid, ret_op, call_op, halt_op, pm_field_op, panel_break, set_soft_flag, soft_flag_value;
  logic branch_on_soft_flag, load_processor_status, branch_on_status, branch_bus_negative, branch_bus_zero;
  logic cond_branch, scratch_no_load, load_pad_pointer, load_scratch_indirect, scratch_load;
  logic branch_taken, stack_overflow, flag_lag, flag_now, ovf_m;
  logic [3:0]  bus_req, stack_pointer;
  logic [4:0]  pad_index_pointer, p;
  logic [31:0] value_word, memory_read_value, adder_result, multiplier_result;
  logic [31:0] pad_bus_out, operand_x, operand_y, scratch_data, rnd, v, m, fm;
  logic [1:0][2:0] wr_req, rd_req;
  microword_hazard_pkg::pad_offset_t [1:0][2:0] wr_off, rd_off;
  microword_hazard_pkg::pad_offset_t o;
  microword_hazard_pkg::status_t status_value, status_mask, st_lag, st_now;
  microword_hazard_pkg::err_vec_t hazard_err;
  int err_total, samples_checked, sp_m, prev, cyc;

  microword_hazard_rules i_dut (.*);

  always #5 clk_sys = ~clk_sys;

  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      conclude();
    end
  end

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic clr();
    {instr_valid, ret_op, call_op, halt_op, pm_field_op, set_soft_flag, soft_flag_value} = 7'h00;
    {branch_on_soft_flag, load_processor_status, branch_on_status, branch_bus_negative} = 4'h0;
    {branch_bus_zero, cond_branch, scratch_no_load, load_pad_pointer, load_scratch_indirect} = 5'h00;
    bus_req = 4'h0;
    {wr_req, rd_req, wr_off, rd_off} = 48'h000000000000;
    value_word = xs();
    memory_read_value = xs();
    adder_result = xs();
    multiplier_result = xs();
    status_value = 4'h5;
    status_mask = 4'hF;
  endtask

  // One cycle: drive, model, then check the registered answer
  task automatic issue(input int op);
    microword_hazard_pkg::err_vec_t e;
    logic [31:0] bus;
    logic tk, vf;
    microword_hazard_pkg::status_t vs;
    int inc;
    e = '0;
    tk = 1'b0;
    instr_valid = op != 0;
    {scratch_no_load, cond_branch, branch_bus_zero, branch_bus_negative, branch_on_status, load_processor_status,
      branch_on_soft_flag, set_soft_flag, pm_field_op, halt_op, call_op, ret_op} = op[11:0];
    vf = flag_lag;
    flag_lag = flag_now;
    vs = st_lag;
    st_lag = st_now;
    bus = (bus_req[3] && !prev[3]) ? value_word : 32'h0;
    if (instr_valid) begin
      if (set_soft_flag) flag_now = soft_flag_value;
      if (load_processor_status) st_now = status_value;
      e[6:0] = {branch_on_status & prev[6], branch_on_soft_flag & prev[4], call_op & prev[2],
        (branch_bus_negative | branch_bus_zero) & prev[3], call_op & op[13], call_op & prev[3], ret_op & prev[0]};
      tk = (branch_on_soft_flag & vf) | (branch_on_status & |(vs & status_mask)) |
        (branch_bus_zero & (bus == 32'h0)) | (branch_bus_negative & bus[31]);
      e[7] = $countones(bus_req) > 1;
      for (int h = 0; h < 2; h++) begin
        e[8 + h] = $countones(wr_req[h]) > 1;
        for (int a = 0; a < 3; a++)
          for (int b = 0; b < 3; b++)
            if (rd_req[h][a] && rd_req[h][b] && rd_off[h][a] != rd_off[h][b]) e[10 + h] = 1'b1;
      end
      e[12] = scratch_no_load & (cond_branch | branch_on_soft_flag | branch_on_status | op[9] | op[8]);
      inc = call_op ? ((e[1] | e[2] | e[4]) ? 2 : 1) : ((ret_op && !prev[0] && sp_m > 0) ? -1 : 0);
      if (sp_m + inc > 15) begin
        e[13] = !ovf_m;
        ovf_m = 1'b1;
        sp_m = 15;
      end else begin
        sp_m = sp_m + inc;
      end
      prev = op;
    end
    @(negedge clk_sys);
    cmp_word({12'h000, branch_taken, stack_overflow, stack_pointer, hazard_err}, {12'h000, tk, ovf_m, 4'(sp_m), e});
    clr();
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rnd = 32'hB48D;
    {panel_break, flag_lag, flag_now, ovf_m, st_lag, st_now} = 12'h000;
    clr();
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    issue(CALL);
    issue(CALL);
    issue(RET);
    issue(RET);
    issue(PM);
    issue(CALL);
    issue(HALT);
    issue(CALL);
    panel_break = 1'b1;
    repeat (3) issue(0);
    panel_break = 1'b0;
    repeat (2) issue(0);
    issue(CALL + BRK);
    $display("Stack sequence test done");
    issue(PM);
    bus_req = 4'h8;
    value_word[0] = 1'b1;
    issue(BBZ);
    issue(PM);
    bus_req = 4'h8;
    value_word[31] = 1'b1;
    issue(BBN);
    soft_flag_value = 1'b1;
    issue(SETF);
    issue(BFL);
    issue(0);
    issue(BFL);
    issue(LDST);
    issue(BST);
    issue(NOP);
    issue(BST);
    $display("Branch test done");
    for (int k = 0; k < 7; k++) begin
      case (k)
        0: bus_req = 4'h3;
        1: wr_req[0] = 3'h5;
        2: wr_req[1] = 3'h6;
        3: rd_req[0] = 3'h3;
        4: rd_req[1] = 3'h3;
        5: rd_req[1] = 3'h5;
        default: bus_req = 4'h8;
      endcase
      {rd_off[0][1], rd_off[1][2]} = 6'h0C;
      issue(k == 6 ? NOLD + CBR : NOP);
    end
    o = 3'(xs());
    v = memory_read_value;
    bus_req = 4'h1;
    {wr_req[0][0], wr_req[1][0], wr_off[0][0], wr_off[1][0]} = {2'h3, o, o};
    issue(NOP);
    cmp_word(pad_bus_out, v);
    {m, fm} = {memory_read_value, multiplier_result};
    {bus_req, load_scratch_indirect, wr_req[0][1], wr_req[1][2]} = 7'h0F;
    {wr_off[0][1], wr_off[1][2]} = {o + 3'h1, o};
    issue(NOP);
    cmp_word(scratch_data, m);
    cmp_word({31'h0, scratch_load}, 32'h1);
    p = 5'(xs());
    {bus_req, value_word, load_pad_pointer} = {4'h8, 27'h0, p, 1'b1};
    {rd_req[0][1], rd_req[1][2], wr_req[0][1], rd_off[0][1], rd_off[1][2], wr_off[0][1]} = {3'h7, o, o, o};
    issue(NOP);
    cmp_word(operand_x, v);
    cmp_word(operand_y, fm);
    cmp_word({27'h0, pad_index_pointer}, {27'h0, p});
    $display("Data pad test done");
    repeat (5) begin
      issue(HALT);
      issue(CALL);
    end
    $display("Overflow test done");
    conclude();
  end
endmodule
`default_nettype wire

// ---- microword_seq_tracker.sv ----
// Instruction history and sequence hazard detection
`timescale 1ns/1ns
`default_nettype none

module microword_seq_tracker (
  input  wire logic   clk_sys,
  input  wire logic   srst,
  hazard_seq_if.tracker seq
);
  logic prev_ret_reg;
  logic prev_ret_next;
  logic prev_pm_reg;
  logic prev_pm_next;
  logic prev_halt_reg;
  logic prev_halt_next;
  logic prev_brk_reg;
  logic prev_brk_next;
  logic prev_set_reg;
  logic prev_set_next;
  logic prev_load_reg;
  logic prev_load_next;

  // History follows instructions; a break is held until the next one
  always_comb begin
    prev_ret_next  = prev_ret_reg;
    prev_pm_next   = prev_pm_reg;
    prev_halt_next = prev_halt_reg;
    prev_set_next  = prev_set_reg;
    prev_load_next = prev_load_reg;
    prev_brk_next  = prev_brk_reg | seq.brk;
    if (seq.valid) begin
      prev_ret_next  = seq.ret;
      prev_pm_next   = seq.pm_field;
      prev_halt_next = seq.halt;
      prev_set_next  = seq.set_flag;
      prev_load_next = seq.load_status;
      prev_brk_next  = seq.brk;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev_ret_reg  <= 1'h0;
      prev_pm_reg   <= 1'h0;
      prev_halt_reg <= 1'h0;
      prev_brk_reg  <= 1'h0;
      prev_set_reg  <= 1'h0;
      prev_load_reg <= 1'h0;
    end else begin
      prev_ret_reg  <= prev_ret_next;
      prev_pm_reg   <= prev_pm_next;
      prev_halt_reg <= prev_halt_next;
      prev_brk_reg  <= prev_brk_next;
      prev_set_reg  <= prev_set_next;
      prev_load_reg <= prev_load_next;
    end
  end

  assign seq.ret_pair     = seq.valid & seq.ret & prev_ret_reg;
  assign seq.pm_call      = seq.valid & seq.call & prev_pm_reg;
  assign seq.brk_call     = seq.valid & seq.call & prev_brk_reg;
  assign seq.halt_call    = seq.valid & seq.call & prev_halt_reg;
  assign seq.bus_zeroed   = seq.valid & seq.bus_branch & prev_pm_reg;
  assign seq.flag_stale   = seq.valid & seq.flag_branch & prev_set_reg;
  assign seq.status_stale = seq.valid & seq.status_branch & prev_load_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_ret_ret;
    seq.valid && seq.ret ##1 seq.valid && seq.ret;
  endsequence
  sequence s_halt_call;
    seq.valid && seq.halt ##1 seq.valid && seq.call;
  endsequence
  sequence s_pm_bus;
    seq.valid && seq.pm_field ##1 seq.valid && seq.bus_branch;
  endsequence
  sequence s_set_branch;
    seq.valid && seq.set_flag ##1 seq.valid && seq.flag_branch;
  endsequence

  a_ret_pair_seen: assert property (s_ret_ret |-> seq.ret_pair)
    else $error("return pair not detected");
  a_halt_call_seen: assert property (s_halt_call |-> seq.halt_call)
    else $error("halt then call not detected");
  a_pm_bus_zero: assert property (s_pm_bus |-> seq.bus_zeroed)
    else $error("bus branch after field not zeroed");
  a_flag_stale_seen: assert property (s_set_branch |-> seq.flag_stale)
    else $error("flag branch too soon not detected");
endmodule

`default_nettype wire
